// ==== design/aux_port_chip_select.v ====
// four-pin auxiliary port with address-decoded chip-select strobes
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "aux_port_chip_select_defs.vh"
`default_nettype none

module aux_port_chip_select (
  input  wire        mclk_in,
  input  wire        reset_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output wire [31:0] hrdata_out,
  input  wire [15:0] ext_addr_in,
  input  wire        ext_rd_n_in,
  input  wire        ext_wr_n_in,
  input  wire [3:0]  aux_pin_in,
  output wire [3:0]  aux_pin_out,
  output wire [3:0]  aux_pin_oe_out
);

  reg  [7:0]  func_low_r;
  reg  [7:0]  func_high_r;
  reg  [3:0]  polarity_r;
  reg  [3:0]  port_data_r;
  reg  [15:0] base0_r;
  reg  [15:0] base1_r;
  reg  [15:0] base2_r;
  reg  [15:0] base3_r;
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [7:0]  idx_r;
  reg         hreadyout_r;
  reg         hresp_r;
  reg  [31:0] hrdata_r;
  reg  [3:0]  pin_r;
  reg  [3:0]  pin_oe_r;
  reg  [3:0]  pin_nxt;
  reg  [3:0]  pin_oe_nxt;
  reg  [31:0] rdata_nxt;
  wire        take;
  wire [7:0]  wbyte;
  wire [7:0]  cfg0;
  wire [7:0]  cfg1;
  wire [7:0]  cfg2;
  wire [7:0]  cfg3;
  wire [1:0]  func0;
  wire [1:0]  func1;
  wire [1:0]  func2;
  wire [1:0]  func3;
  wire [1:0]  len0;
  wire [1:0]  len1;
  wire [1:0]  len2;
  wire [1:0]  len3;
  wire        rd_req;
  wire        wr_req;
  wire        hit0;
  wire        hit1;
  wire        hit2;
  wire        hit3;
  wire        act0;
  wire        act1;
  wire        act2;
  wire        act3;
  wire        we_cs0_lo;
  wire        we_cs0_hi;
  wire        we_cs1_lo;
  wire        we_cs1_hi;
  wire        we_cs2_lo;
  wire        we_cs2_hi;
  wire        we_cs3_lo;
  wire        we_cs3_hi;
  wire        we_pol;
  wire        we_func_lo;
  wire        we_func_hi;
  wire        we_data;

  // address match on the compared bits only
  function match;
    input [15:0] addr;
    input [15:0] base;
    input [1:0]  len;
    reg   [15:0] mask;
    begin
      case (len)
        `CMP_ALL16:  mask = `MASK_ALL16;
        `CMP_A15_A1: mask = `MASK_A15_A1;
        `CMP_A15_A2: mask = `MASK_A15_A2;
        `CMP_A15_A8: mask = `MASK_A15_A8;
        default:     mask = `MASK_ALL16;
      endcase
      match = ((addr & mask) == (base & mask));
    end
  endfunction

  // strobe active for this pin's function and the core's strobes
  function strobe;
    input [1:0] func;
    input       hit;
    input       rd;
    input       wr;
    begin
      case (func)
        `FUNC_RD_STROBE: strobe = hit & rd;
        `FUNC_WR_STROBE: strobe = hit & wr;
        `FUNC_RW_STROBE: strobe = hit & (rd | wr);
        default:         strobe = 1'b0;
      endcase
    end
  endfunction

  // level on a strobe pin; polarity 1 means active high
  function level;
    input pol;
    input act;
    begin
      level = pol ? act : ~act;
    end
  endfunction

  // index compare, shared by every write enable
  function sel;
    input [7:0] idx;
    input [7:0] code;
    begin
      sel = (idx == code);
    end
  endfunction

  assign take  = hsel_in & htrans_in[`HTRANS_NONSEQ_BIT] & hready_in;
  assign wbyte = hwdata_in[7:0];
  // per-pin {function, length}
  // high control holds pins 3 and 2, low control holds pins 1 and 0
  assign cfg3  = {4'h0, func_high_r[7:4]};
  assign cfg2  = {4'h0, func_high_r[3:0]};
  assign cfg1  = {4'h0, func_low_r[7:4]};
  assign cfg0  = {4'h0, func_low_r[3:0]};
  assign func0 = cfg0[`FUNC_MSB:`FUNC_LSB];
  assign func1 = cfg1[`FUNC_MSB:`FUNC_LSB];
  assign func2 = cfg2[`FUNC_MSB:`FUNC_LSB];
  assign func3 = cfg3[`FUNC_MSB:`FUNC_LSB];
  assign len0  = cfg0[`LEN_MSB:`LEN_LSB];
  assign len1  = cfg1[`LEN_MSB:`LEN_LSB];
  assign len2  = cfg2[`LEN_MSB:`LEN_LSB];
  assign len3  = cfg3[`LEN_MSB:`LEN_LSB];
  // core strobes arrive active low
  assign rd_req = ~ext_rd_n_in;
  assign wr_req = ~ext_wr_n_in;
  // compare on the selected bits only
  assign hit0  = match(ext_addr_in, base0_r, len0);
  assign hit1  = match(ext_addr_in, base1_r, len1);
  assign hit2  = match(ext_addr_in, base2_r, len2);
  assign hit3  = match(ext_addr_in, base3_r, len3);
  assign act0  = strobe(func0, hit0, rd_req, wr_req);
  assign act1  = strobe(func1, hit1, rd_req, wr_req);
  assign act2  = strobe(func2, hit2, rd_req, wr_req);
  assign act3  = strobe(func3, hit3, rd_req, wr_req);
  // a write lands in its data phase, so a read right after sees it
  assign we_cs0_lo  = wr_pend_r & sel(idx_r, `IDX_CS0_BASE_LOW);
  assign we_cs0_hi  = wr_pend_r & sel(idx_r, `IDX_CS0_BASE_HIGH);
  assign we_cs1_lo  = wr_pend_r & sel(idx_r, `IDX_CS1_BASE_LOW);
  assign we_cs1_hi  = wr_pend_r & sel(idx_r, `IDX_CS1_BASE_HIGH);
  assign we_cs2_lo  = wr_pend_r & sel(idx_r, `IDX_CS2_BASE_LOW);
  assign we_cs2_hi  = wr_pend_r & sel(idx_r, `IDX_CS2_BASE_HIGH);
  assign we_cs3_lo  = wr_pend_r & sel(idx_r, `IDX_CS3_BASE_LOW);
  assign we_cs3_hi  = wr_pend_r & sel(idx_r, `IDX_CS3_BASE_HIGH);
  assign we_pol     = wr_pend_r & sel(idx_r, `IDX_STROBE_POLARITY);
  assign we_func_lo = wr_pend_r & sel(idx_r, `IDX_PIN_FUNC_CTRL_LOW);
  assign we_func_hi = wr_pend_r & sel(idx_r, `IDX_PIN_FUNC_CTRL_HIGH);
  assign we_data    = wr_pend_r & sel(idx_r, `IDX_AUX_PORT_DATA);

  // bus slave: writes finish with no wait, reads take one wait state
  // so that a write just ahead of the read is already visible
  always @(posedge mclk_in) begin
    if (reset_in) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      idx_r       <= `RST_BYTE;
      hreadyout_r <= 1'b1;
      hresp_r     <= `HRESP_OKAY;
      hrdata_r    <= 32'h0000_0000;
    end else begin
      hresp_r <= `HRESP_OKAY;
      if (rd_pend_r) begin
        rd_pend_r   <= 1'b0;
        hreadyout_r <= 1'b1;
        hrdata_r    <= rdata_nxt;
      end else begin
        wr_pend_r <= take & hwrite_in;
        rd_pend_r <= take & ~hwrite_in;
        if (take) begin
          idx_r <= haddr_in[`HADDR_IDX_MSB:`HADDR_IDX_LSB];
        end
        hreadyout_r <= ~(take & ~hwrite_in);
      end
    end
  end

  // read mux; unmapped words and reserved bits read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (idx_r)
      `IDX_CS0_BASE_LOW:       rdata_nxt[7:0] = base0_r[7:0];
      `IDX_CS0_BASE_HIGH:      rdata_nxt[7:0] = base0_r[15:8];
      `IDX_CS1_BASE_LOW:       rdata_nxt[7:0] = base1_r[7:0];
      `IDX_CS1_BASE_HIGH:      rdata_nxt[7:0] = base1_r[15:8];
      `IDX_CS2_BASE_LOW:       rdata_nxt[7:0] = base2_r[7:0];
      `IDX_CS2_BASE_HIGH:      rdata_nxt[7:0] = base2_r[15:8];
      `IDX_CS3_BASE_LOW:       rdata_nxt[7:0] = base3_r[7:0];
      `IDX_CS3_BASE_HIGH:      rdata_nxt[7:0] = base3_r[15:8];
      `IDX_STROBE_POLARITY:    rdata_nxt[`POL_MSB:`POL_LSB] = polarity_r;
      `IDX_PIN_FUNC_CTRL_LOW:  rdata_nxt[7:0] = func_low_r;
      `IDX_PIN_FUNC_CTRL_HIGH: rdata_nxt[7:0] = func_high_r;
      // port read returns the pin levels, as a port does
      `IDX_AUX_PORT_DATA:      rdata_nxt[3:0] = aux_pin_in;
      default:                 rdata_nxt = 32'h0000_0000;
    endcase
  end

  // register writes, taken in the data phase
  // control registers
  always @(posedge mclk_in) begin
    if (reset_in) begin
      func_low_r  <= `RST_BYTE;
      func_high_r <= `RST_BYTE;
    end else begin
      if (we_func_lo) begin
        func_low_r <= wbyte;
      end
      if (we_func_hi) begin
        func_high_r <= wbyte;
      end
    end
  end

  // polarity bits; the low nibble stays reserved
  always @(posedge mclk_in) begin
    if (reset_in) begin
      polarity_r <= `RST_POL;
    end else if (we_pol) begin
      polarity_r <= wbyte[`POL_MSB:`POL_LSB];
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      port_data_r <= `RST_PORT_DATA;
    end else if (we_data) begin
      port_data_r <= wbyte[`DATA_MSB:`DATA_LSB];
    end
  end

  // base address bytes, each half written on its own
  always @(posedge mclk_in) begin
    if (reset_in) begin
      base0_r <= `RST_BASE;
      base1_r <= `RST_BASE;
      base2_r <= `RST_BASE;
      base3_r <= `RST_BASE;
    end else begin
      if (we_cs0_lo) begin
        base0_r[7:0] <= wbyte;
      end
      if (we_cs0_hi) begin
        base0_r[15:8] <= wbyte;
      end
      if (we_cs1_lo) begin
        base1_r[7:0] <= wbyte;
      end
      if (we_cs1_hi) begin
        base1_r[15:8] <= wbyte;
      end
      if (we_cs2_lo) begin
        base2_r[7:0] <= wbyte;
      end
      if (we_cs2_hi) begin
        base2_r[15:8] <= wbyte;
      end
      if (we_cs3_lo) begin
        base3_r[7:0] <= wbyte;
      end
      if (we_cs3_hi) begin
        base3_r[15:8] <= wbyte;
      end
    end
  end

  // pin drive; one flop of latency behind the core strobes
  // costs a clock of strobe delay, but the pins never glitch on decode
  always @* begin
    pin_nxt    = 4'h0;
    pin_oe_nxt = 4'h0;
    // quasi-bidirectional: drive low, release high to pull-up
    if (func0 == `FUNC_PORT) begin
      pin_nxt[0]    = port_data_r[0];
      pin_oe_nxt[0] = ~port_data_r[0];
    end else begin
      // polarity applied; idle gives inactive level
      pin_nxt[0]    = level(polarity_r[0], act0);
      pin_oe_nxt[0] = 1'b1;
    end
    if (func1 == `FUNC_PORT) begin
      pin_nxt[1]    = port_data_r[1];
      pin_oe_nxt[1] = ~port_data_r[1];
    end else begin
      pin_nxt[1]    = level(polarity_r[1], act1);
      pin_oe_nxt[1] = 1'b1;
    end
    if (func2 == `FUNC_PORT) begin
      pin_nxt[2]    = port_data_r[2];
      pin_oe_nxt[2] = ~port_data_r[2];
    end else begin
      pin_nxt[2]    = level(polarity_r[2], act2);
      pin_oe_nxt[2] = 1'b1;
    end
    if (func3 == `FUNC_PORT) begin
      pin_nxt[3]    = port_data_r[3];
      pin_oe_nxt[3] = ~port_data_r[3];
    end else begin
      pin_nxt[3]    = level(polarity_r[3], act3);
      pin_oe_nxt[3] = 1'b1;
    end
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      pin_r    <= `RST_PORT_DATA;
      pin_oe_r <= 4'h0;
    end else begin
      pin_r    <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign hreadyout_out  = hreadyout_r;
  assign hresp_out      = hresp_r;
  assign hrdata_out     = hrdata_r;
  assign aux_pin_out    = pin_r;
  assign aux_pin_oe_out = pin_oe_r;

endmodule

`default_nettype wire

// ==== pkg/aux_port_chip_select_defs.vh ====
// register map, field layout and reset values of the auxiliary port
`ifndef AUX_PORT_CHIP_SELECT_DEFS_VH
`define AUX_PORT_CHIP_SELECT_DEFS_VH

// register indices; byte address on the bus is four times the index
`define IDX_CS0_BASE_LOW        8'h84
`define IDX_CS0_BASE_HIGH       8'h85
`define IDX_CS1_BASE_LOW        8'h94
`define IDX_CS1_BASE_HIGH       8'h95
`define IDX_CS2_BASE_LOW        8'hac
`define IDX_CS2_BASE_HIGH       8'had
`define IDX_STROBE_POLARITY     8'hae
`define IDX_CS3_BASE_LOW        8'hb4
`define IDX_CS3_BASE_HIGH       8'hb5
`define IDX_PIN_FUNC_CTRL_LOW   8'hc2
`define IDX_PIN_FUNC_CTRL_HIGH  8'hc3
`define IDX_AUX_PORT_DATA       8'hd8

// reset values
`define RST_BYTE                8'h00
`define RST_PORT_DATA           4'hf
`define RST_POL                 4'h0
`define RST_BASE                16'h0000

// register index field of the bus byte address
`define HADDR_IDX_MSB           9
`define HADDR_IDX_LSB           2

// data register bits that drive port-mode pins
`define DATA_MSB                3
`define DATA_LSB                0

// field positions inside a per-pin {function, length} nibble
`define FUNC_MSB                3
`define FUNC_LSB                2
`define LEN_MSB                 1
`define LEN_LSB                 0

// writable polarity bits sit in bits 7..4, below reads as zero
`define POL_LSB                 4
`define POL_MSB                 7

// pin function field
`define FUNC_PORT               2'b00
`define FUNC_RD_STROBE          2'b01
`define FUNC_WR_STROBE          2'b10
`define FUNC_RW_STROBE          2'b11

// comparison length field
`define CMP_ALL16               2'b00
`define CMP_A15_A1              2'b01
`define CMP_A15_A2              2'b10
`define CMP_A15_A8              2'b11

// compare masks for each length
`define MASK_ALL16              16'hffff
`define MASK_A15_A1             16'hfffe
`define MASK_A15_A2             16'hfffc
`define MASK_A15_A8             16'hff00

// ahb encodings
`define HTRANS_NONSEQ_BIT       1
`define HRESP_OKAY              1'b0

`endif

// ==== verif/ext_periph.sv ====
// board model: pull-ups on every pin
`default_nettype none
module ext_periph (
  input  wire logic [3:0] pins_in,
  input  wire logic [3:0] oe_in,
  output logic      [3:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released pin floats up, it never keeps its last driven value
  assign level_out = pins_in | ~oe_in;
endmodule
`default_nettype wire

// ==== verif/aux_port_chip_select_properties.sv ====
// port checks for the auxiliary chip-select block
`default_nettype none
module aux_port_chip_select_chk (
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic        hready_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic [15:0] ext_addr_in,
  input wire logic        ext_rd_n_in,
  input wire logic        ext_wr_n_in,
  input wire logic [3:0]  aux_pin_out,
  input wire logic [3:0]  aux_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wr_r;
  logic        rd_r;
  logic [17:0] ext_r;
  wire         take = hsel_in & htrans_in[1] & hready_in;
  // besides a register write, only a move on the external bus may move a pin
  wire         moved = {ext_addr_in, ext_rd_n_in, ext_wr_n_in} != ext_r;
  always_ff @(posedge mclk_in) begin
    ext_r <= {ext_addr_in, ext_rd_n_in, ext_wr_n_in};
    wr_r <= take & hwrite_in & ~reset_in;
    rd_r <= take & ~hwrite_in & ~reset_in;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  released_high_a: assert property ((~aux_pin_oe_out & ~aux_pin_out) == 4'h0)
    else $error("released pin low");
  pin_cause_a: assert property ($changed(aux_pin_out) |->
    $past(moved) || $past(wr_r) || $past(wr_r, 2) || $past(wr_r, 3))
    else $error("pin moved without cause");
  drive_cause_a: assert property ($changed(aux_pin_oe_out) |->
    $past(wr_r) || $past(wr_r, 2) || $past(wr_r, 3))
    else $error("pin drive moved without write");
  read_wait_a: assert property (take & ~hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait wrong");
  write_nowait_a: assert property (take & hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  resp_okay_a: assert property (hresp_out == 1'h0)
    else $error("error response");
  rdata_upper_a: assert property (hrdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  rdata_hold_a: assert property ($changed(hrdata_out) |-> $past(rd_r))
    else $error("read data moved");
endmodule
bind aux_port_chip_select aux_port_chip_select_chk chk (
  .mclk_in, .reset_in, .hsel_in, .hready_in, .htrans_in, .hwrite_in,
  .hreadyout_out, .hresp_out, .hrdata_out, .ext_addr_in, .ext_rd_n_in,
  .ext_wr_n_in, .aux_pin_out, .aux_pin_oe_out
);
`default_nettype wire

// ==== verif/aux_port_chip_select_test.sv ====
// self-checking bench for the auxiliary chip-select block
`include "aux_port_chip_select_defs.vh"
`default_nettype none
module aux_port_chip_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 1'h0;
  logic        reset_in = 1'h1;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [15:0] ext_addr_in = 16'h0;
  logic        ext_rd_n_in = 1'h1;
  logic        ext_wr_n_in = 1'h1;
  wire         hreadyout_out;
  wire  [31:0] hrdata_out;
  wire  [3:0]  aux_pin_out;
  wire  [3:0]  aux_pin_oe_out;
  wire  [3:0]  lvl;
  logic [7:0]  rv;
  int          n_fail = 0;
  int          tests_run = 0;
  aux_port_chip_select uut (
    .mclk_in, .reset_in, .hsel_in(1'h1), .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out,
    .hresp_out(), .hrdata_out, .ext_addr_in, .ext_rd_n_in, .ext_wr_n_in,
    .aux_pin_in(lvl), .aux_pin_out, .aux_pin_oe_out
  );
  ext_periph board (.pins_in(aux_pin_out), .oe_in(aux_pin_oe_out), .level_out(lvl));
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wt;
    for (int n = 0; n < 9; n++) begin
      @(posedge mclk_in);
      if (hreadyout_out === 1'h1) return;
    end
    n_fail++;
    conclude();
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    htrans_in <= 2'h2;
    haddr_in <= {22'h0, i, 2'h0};
    hwrite_in <= w;
    wt();
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    wt();
    rv = hrdata_out[7:0];
  endtask
  task automatic rchk(input string s, input logic [7:0] i, input logic [7:0] e);
    bus(1'h0, i, 8'h0);
    chk(s, e, rv);
  endtask
  // pins are registered, so the answer is looked at one edge after the sample
  task automatic ext(input logic [15:0] a, input logic r, input logic w);
    ext_addr_in <= a;
    ext_rd_n_in <= ~r;
    ext_wr_n_in <= ~w;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic reg_scn;
    rchk("pol rst", `IDX_STROBE_POLARITY, 8'h00);
    rchk("levels", `IDX_AUX_PORT_DATA, 8'h0f);
    bus(1'h1, `IDX_STROBE_POLARITY, 8'hff);
    rchk("pol", `IDX_STROBE_POLARITY, 8'hf0);
    bus(1'h1, `IDX_PIN_FUNC_CTRL_HIGH, 8'h33);
    rchk("ctl hi", `IDX_PIN_FUNC_CTRL_HIGH, 8'h33);
    bus(1'h1, `IDX_CS3_BASE_HIGH, 8'h5a);
    rchk("base hi", `IDX_CS3_BASE_HIGH, 8'h5a);
    rchk("unmapped", 8'h10, 8'h00);
  endtask
  task automatic len_scn;
    logic [15:0] mk [4];
    logic [15:0] ad [5];
    logic        hit;
    mk = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
    ad = '{16'h1234, 16'h1235, 16'h1237, 16'h12ff, 16'h1334};
    bus(1'h1, `IDX_CS0_BASE_HIGH, 8'h12);
    bus(1'h1, `IDX_CS0_BASE_LOW, 8'h34);
    bus(1'h1, `IDX_STROBE_POLARITY, 8'h10);
    bus(1'h1, `IDX_AUX_PORT_DATA, 8'h05);
    for (int l = 0; l < 4; l++) begin
      bus(1'h1, `IDX_PIN_FUNC_CTRL_LOW, 8'h08 | l[7:0]);
      for (int k = 0; k < 5; k++) begin
        ext(ad[k], 1'h0, 1'h1);
        hit = ((ad[k] ^ 16'h1234) & mk[l]) == 16'h0;
        chk("wr len", {7'h02, hit}, {4'h0, aux_pin_out});
      end
    end
    ext(16'h1234, 1'h1, 1'h0);
    chk("rd on wr", 8'hb4, {aux_pin_oe_out, aux_pin_out});
    bus(1'h1, `IDX_AUX_PORT_DATA, 8'h0b);
    ext(16'h0, 1'h0, 1'h0);
    chk("port wr", 8'h5a, {aux_pin_oe_out, aux_pin_out});
  endtask
  task automatic func_scn;
    bus(1'h1, `IDX_CS2_BASE_HIGH, 8'hab);
    bus(1'h1, `IDX_CS2_BASE_LOW, 8'hcd);
    for (int f = 1; f < 4; f++) begin
      bus(1'h1, `IDX_PIN_FUNC_CTRL_HIGH, {4'h0, f[1:0], 2'h3});
      for (int r = 0; r < 2; r++) begin
        ext(16'hab42, r[0], ~r[0]);
        chk("pin2", {7'h0, ~(r[0] ? f[0] : f[1])}, {7'h0, aux_pin_out[2]});
      end
      ext(16'hac42, 1'h0, 1'h1);
      chk("pin2 idle", 8'h01, {7'h0, aux_pin_out[2]});
    end
  endtask
  // reset in mid-run: pins and registers fall back to their reset state
  task automatic rst_scn;
    reset_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'h0;
    @(posedge mclk_in);
    chk("rst pins", 8'h0f, {aux_pin_oe_out, aux_pin_out});
    rchk("rst pol", `IDX_STROBE_POLARITY, 8'h00);
    rchk("rst ctl", `IDX_PIN_FUNC_CTRL_LOW, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'h0;
    @(posedge mclk_in);
    reg_scn();
    len_scn();
    func_scn();
    rst_scn();
    conclude();
  end
endmodule
`default_nettype wire
